//--- include/eip_pkg.sv
/*
 * Constants for the external interrupt pin interface: register map, field
 * positions, reset values and acknowledge timing.
 * Assumes a 25 MHz system clock and a 32-bit APB register bus.
 */
package eip_pkg;

    // Sizes
    localparam int          NUM_REQ       = 5;
    localparam int          TYPE_W        = 8;
    localparam int          SRC_W         = 3;
    localparam int          ADDR_W        = 8;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_TRIG      = 8'h04;
    localparam logic [7:0]  OFS_REQMASK   = 8'h08;
    localparam logic [7:0]  OFS_PEND      = 8'h0C;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [7:0]  OFS_IMASK     = 8'h14;
    localparam logic [7:0]  OFS_VECTOR    = 8'h18;

    // Control register fields
    localparam int          CTRL_CASC0    = 0;
    localparam int          CTRL_CASC1    = 1;
    localparam int          CTRL_SLAVE    = 2;
    localparam int          CTRL_SLVIRQ   = 3;
    localparam int          CTRL_W        = 4;

    // Vector register fields
    localparam int          VEC_ENTRY_LSB = 0;
    localparam int          VEC_SRC_LSB   = 8;
    localparam int          VEC_VALID     = 16;

    // Reset values
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [4:0]  TRIG_RST      = 5'h00;
    localparam logic [4:0]  REQMASK_RST   = 5'h1F;
    localparam logic [4:0]  IMASK_RST     = 5'h00;

    // Table entry of request input zero; the others follow in order
    localparam logic [7:0]  VEC_BASE      = 8'h20;

    // Acknowledge low time, rounded up to whole cycles
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          ACK_LOW_NS    = 160;
    localparam int          ACK_CYCLES    = (ACK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  ACK_LAST      = 3'(ACK_CYCLES - 1);

    // Service sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACK,
        ST_SELECT,
        ST_SERVE
    } eip_state_type;

endpackage

//--- design/eip_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes each bit is independent; a multi-bit value is only trusted
 * after it has been stable for longer than the synchroniser delay.
 */
`timescale 1ns/1ps

module eip_sync #(
    parameter int WIDTH = 13
) (
    input  wire logic             clk_sys,   // System clock
    input  wire logic             reset,     // Synchronous reset, high
    input  wire logic [WIDTH-1:0] asyncIn,   // Raw pin levels
    output logic      [WIDTH-1:0] syncOut    // Levels in clock domain
);

    logic [WIDTH-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_r  <= '0;
            syncOut <= '0;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule

//--- design/eip_req_detect.sv
/*
 * Request detection for the maskable request inputs: rising-edge latch or
 * plain level, chosen per input.
 * Assumes synchronised inputs; a clear and a new edge in one cycle keep
 * the request.
 */
`timescale 1ns/1ps

module eip_req_detect
    import eip_pkg::*;
(
    input  wire logic               clk_sys,   // System clock
    input  wire logic               reset,     // Synchronous reset, high
    input  wire logic [NUM_REQ-1:0] reqSync,   // Synchronised request levels
    input  wire logic [NUM_REQ-1:0] trigEdge,  // 1 edge, 0 level per input
    input  wire logic [NUM_REQ-1:0] clrLatch,  // Acknowledge clears latch
    output logic      [NUM_REQ-1:0] pending    // Detected requests
);

    ////////////////////////////////////////////////////////////////////////
    // One detector per input; each keeps its own flops, one writer per bit
    genvar i;
    generate
        for (i = 0; i < NUM_REQ; i++) begin : g_det
            logic prev_r;
            logic latch_r;
            wire  rise      = reqSync[i] & ~prev_r;
            wire  latch_nxt = (latch_r & ~clrLatch[i]) | rise;

            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    prev_r  <= 1'b0;
                    latch_r <= 1'b0;
                end else begin
                    prev_r  <= reqSync[i];
                    latch_r <= latch_nxt;
                end
            end

            // Level mode follows the pin, so the requester must hold it
            assign pending[i] = trigEdge[i] ? latch_r : reqSync[i];
        end
    endgenerate

endmodule

//--- design/eip_pin_if.sv
/*
 * External interrupt pin interface: five maskable request pins, cascade
 * acknowledge outputs, slave select and slave request, APB registers.
 * Assumes pins are asynchronous to clk_sys and that software ends each
 * service by writing the vector register.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Every request pin is passed through two flip-flops before use.
// - Each request input is set by software to rising edge or level.
// - An unmasked request on an input with no cascade or slave role presents its own table entry; masked ones do nothing.
// - Cascade on input zero turns pin two into its acknowledge output.
// - In cascade the acknowledge zero output asks for a type for input zero.
// - Cascade on input one turns pin three into its acknowledge output.
// - In cascade the acknowledge one output asks for a type for input one.
// - In slave mode pin one is a select input marking a type on the bus.
// - In slave mode pin three drives the device's own request to the master.
// - Input four stays a plain maskable request with its own entry.

module eip_pin_if
    import eip_pkg::*;
(
    input  wire logic              clk_sys,          // System clock, 25 MHz
    input  wire logic              reset,            // Synchronous reset, high
    // APB slave
    input  wire logic              psel,             // Slave select
    input  wire logic              penable,          // Access phase
    input  wire logic              pwrite,           // Write when high
    input  wire logic [ADDR_W-1:0] paddr,            // Byte address
    input  wire logic [31:0]       pwdata,           // Write data
    output logic      [31:0]       prdata,           // Read data
    output logic                   pready,           // Transfer done
    output logic                   pslverr,          // Unmapped address
    // Request pins
    input  wire logic              reqInZero,        // Request pin zero
    input  wire logic              reqInOne,         // Request pin one, or select
    input  wire logic              reqInTwo,         // Request pin two, level in
    output logic                   reqTwoOut,        // Pin two level out
    output logic                   reqTwoOeN,        // Pin two drive, low active
    input  wire logic              reqInThree,       // Request pin three, level in
    output logic                   reqThreeOut,      // Pin three level out
    output logic                   reqThreeOeN,      // Pin three drive, low active
    input  wire logic              reqInFour,        // Request pin four
    input  wire logic [TYPE_W-1:0] adBusIn,          // Low data lines in
    // Core side
    output logic                   vectorValid,      // Table entry ready
    output logic      [TYPE_W-1:0] vectorEntry,      // Table entry number
    output logic                   irqOut            // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [CTRL_W-1:0]  ctrl_r;
    logic [NUM_REQ-1:0] trig_r;
    logic [NUM_REQ-1:0] reqMask_r;
    logic [NUM_REQ-1:0] status_r;
    logic [NUM_REQ-1:0] iMask_r;
    logic [SRC_W-1:0]   src_r;
    logic [2:0]         ackCnt_r;
    eip_state_type      state_r;
    eip_state_type      state_nxt;

    logic [NUM_REQ-1:0] reqSync;
    logic [TYPE_W-1:0]  adSync;
    logic [NUM_REQ-1:0] pending;
    logic [NUM_REQ-1:0] clrLatch;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lowest numbered request wins
    function automatic logic [SRC_W-1:0] first_req(input logic [NUM_REQ-1:0] v);
        logic [SRC_W-1:0] idx;
        idx = '0;
        for (int k = NUM_REQ - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = SRC_W'(k);
            end
        end
        return idx;
    endfunction

    // Register word compare, shared by every access decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    eip_sync #(
        .WIDTH (NUM_REQ + TYPE_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .asyncIn ({adBusIn, reqInFour, reqInThree, reqInTwo, reqInOne, reqInZero}),
        .syncOut ({adSync, reqSync})
    );

    eip_req_detect u_det (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .reqSync  (reqSync),
        .trigEdge (trig_r),
        .clrLatch (clrLatch),
        .pending  (pending)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin roles by mode

    wire cascZero  = ctrl_r[CTRL_CASC0];
    wire cascOne   = ctrl_r[CTRL_CASC1];
    wire slaveMode = ctrl_r[CTRL_SLAVE];
    wire selSync   = reqSync[1];

    // Pins turned into outputs or a select no longer request
    wire [NUM_REQ-1:0] srcEn = {1'b1,
                                ~(cascOne | slaveMode),
                                ~cascZero,
                                ~slaveMode,
                                1'b1};
    wire [NUM_REQ-1:0] cand  = pending & srcEn & ~reqMask_r;
    wire [SRC_W-1:0]   pick  = first_req(cand);
    wire               pickCasc = ((pick == 3'h0) && cascZero) ||
                                  ((pick == 3'h1) && cascOne);
    wire               pickSlave = (pick == 3'h0) && slaveMode && !cascZero;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire setupPh  = psel & ~penable;
    wire accessOk = psel & penable & pready;
    wire wrEn     = accessOk & pwrite;
    wire wrCtrl   = wrEn & hit(paddr, OFS_CTRL);
    wire wrTrig   = wrEn & hit(paddr, OFS_TRIG);
    wire wrReqMsk = wrEn & hit(paddr, OFS_REQMASK);
    wire wrStatus = wrEn & hit(paddr, OFS_STATUS);
    wire wrIMask  = wrEn & hit(paddr, OFS_IMASK);
    wire wrVector = wrEn & hit(paddr, OFS_VECTOR);
    wire mapped   = hit(paddr, OFS_CTRL) | hit(paddr, OFS_TRIG) |
                    hit(paddr, OFS_REQMASK) | hit(paddr, OFS_PEND) |
                    hit(paddr, OFS_STATUS) | hit(paddr, OFS_IMASK) |
                    hit(paddr, OFS_VECTOR);

    wire [31:0] vecWord = {15'h0000, vectorValid, 5'h00, src_r, vectorEntry};
    wire [31:0] rdMux   =
        hit(paddr, OFS_CTRL)    ? {28'h0000000, ctrl_r}            :
        hit(paddr, OFS_TRIG)    ? {27'h0000000, trig_r}            :
        hit(paddr, OFS_REQMASK) ? {27'h0000000, reqMask_r}         :
        hit(paddr, OFS_PEND)    ? {22'h000000, reqSync, pending}   :
        hit(paddr, OFS_STATUS)  ? {27'h0000000, status_r}          :
        hit(paddr, OFS_IMASK)   ? {27'h0000000, iMask_r}           :
        hit(paddr, OFS_VECTOR)  ? vecWord                          : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Service sequencer

    wire idleTake = (state_r == ST_IDLE) && (cand != 5'h00);
    wire ackDone  = (state_r == ST_ACK) && (ackCnt_r == ACK_LAST);
    wire selTake  = (state_r == ST_SELECT) && selSync;
    wire serveEnd = (state_r == ST_SERVE) && wrVector;

    // Edge latch is cleared once the request is taken
    assign clrLatch = idleTake ? (5'h01 << pick) : 5'h00;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (idleTake) begin
                    if (pickCasc) begin
                        state_nxt = ST_ACK;
                    end else if (pickSlave) begin
                        state_nxt = ST_SELECT;
                    end else begin
                        state_nxt = ST_SERVE;
                    end
                end
            end
            ST_ACK: begin
                if (ackDone) begin
                    state_nxt = ST_SERVE;
                end
            end
            ST_SELECT: begin
                if (selTake) begin
                    state_nxt = ST_SERVE;
                end
            end
            ST_SERVE: begin
                if (serveEnd) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Fixed entries for the own-table case, bus byte otherwise
    wire [TYPE_W-1:0] ownEntry = VEC_BASE + TYPE_W'(pick);
    wire              takeBus  = ackDone | selTake;
    wire [NUM_REQ-1:0] evSet   = idleTake ? (5'h01 << pick) : 5'h00;
    wire [NUM_REQ-1:0] status_nxt = (status_r & ~(wrStatus ? pwdata[4:0] : 5'h00)) | evSet;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r  <= ST_IDLE;
            src_r    <= '0;
            ackCnt_r <= '0;
        end else begin
            state_r  <= state_nxt;
            ackCnt_r <= (state_r == ST_ACK) ? ackCnt_r + 3'h1 : 3'h0;
            if (idleTake) begin
                src_r <= pick;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vectorValid <= 1'b0;
            vectorEntry <= '0;
        end else begin
            if (idleTake && !pickCasc && !pickSlave) begin
                vectorValid <= 1'b1;
                vectorEntry <= ownEntry;
            end else if (takeBus) begin
                vectorValid <= 1'b1;
                vectorEntry <= adSync;
            end else if (serveEnd) begin
                vectorValid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers; acknowledges are low while a type is wanted

    wire ackZeroNxt = ~((state_nxt == ST_ACK) && (idleTake ? pick : src_r) == 3'h0);
    wire ackOneNxt  = ~((state_nxt == ST_ACK) && (idleTake ? pick : src_r) == 3'h1);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reqTwoOut   <= 1'b1;
            reqTwoOeN   <= 1'b1;
            reqThreeOut <= 1'b1;
            reqThreeOeN <= 1'b1;
        end else begin
            reqTwoOeN   <= ~cascZero;
            reqTwoOut   <= ackZeroNxt;
            reqThreeOeN <= ~(cascOne | slaveMode);
            reqThreeOut <= cascOne ? ackOneNxt
                                   : ctrl_r[CTRL_SLVIRQ];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file; a new event beats a same-cycle clear

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_r    <= CTRL_RST;
            trig_r    <= TRIG_RST;
            reqMask_r <= REQMASK_RST;
            status_r  <= '0;
            iMask_r   <= IMASK_RST;
            irqOut    <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= pwdata[CTRL_W-1:0];
            end
            if (wrTrig) begin
                trig_r <= pwdata[NUM_REQ-1:0];
            end
            if (wrReqMsk) begin
                reqMask_r <= pwdata[NUM_REQ-1:0];
            end
            if (wrIMask) begin
                iMask_r <= pwdata[NUM_REQ-1:0];
            end
            status_r <= status_nxt;
            irqOut   <= |(status_nxt & (wrIMask ? pwdata[4:0] : iMask_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: ready in the access cycle, no wait states

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPh;
            pslverr <= setupPh & ~mapped;
            if (setupPh && !pwrite) begin
                prdata <= rdMux;
            end
        end
    end

endmodule

//--- verif/eip_pin_if_asserts.sv
/* Checker for the pin interface: APB timing, acknowledge pulses, entries.
   Assumes a bind into eip_pin_if; sees only its ports. */
`timescale 1ns/1ps

module eip_chk
    import eip_pkg::*;
(
    input wire logic              clk_sys,     // System clock
    input wire logic              reset,       // Synchronous reset
    input wire logic              psel,        // APB select
    input wire logic              penable,     // APB access
    input wire logic              pwrite,      // APB write
    input wire logic [ADDR_W-1:0] paddr,       // APB address
    input wire logic              pready,      // APB ready
    input wire logic              pslverr,     // APB error
    input wire logic              reqTwoOut,   // Pin two drive
    input wire logic              reqTwoOeN,   // Pin two enable
    input wire logic              reqThreeOeN, // Pin three enable
    input wire logic              vectorValid, // Entry ready
    input wire logic [TYPE_W-1:0] vectorEntry  // Entry number
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Vector write ends a service
    wire vecWr = psel && penable && pwrite && paddr == OFS_VECTOR;
    ////////////////////////////////////////////////////////////////////////
    // Zero wait states: one-cycle answers
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Acknowledge zero: four cycles, then the type
    ack_len_a: assert property ($fell(reqTwoOut) |-> !reqTwoOut [*4] ##1 reqTwoOut)
        else $error("acknowledge zero length wrong");
    ack_type_a: assert property ($rose(reqTwoOut) |-> vectorValid)
        else $error("no entry at end of acknowledge");
    ack_drive_a: assert property (!reqTwoOut |-> !reqTwoOeN)
        else $error("acknowledge zero not driven");
    ack_idle_a: assert property (!reqTwoOut |-> !vectorValid)
        else $error("acknowledge during a service");
    // Entry stands until the service ends
    vec_hold_a: assert property (vectorValid && !vecWr |=>
        vectorValid && $stable(vectorEntry))
        else $error("entry dropped or changed");
    vec_end_a: assert property (vectorValid && vecWr |=> !vectorValid)
        else $error("service did not end");
    entry_own_a: assert property ($rose(vectorValid) && reqTwoOeN && reqThreeOeN
        |-> vectorEntry >= VEC_BASE && vectorEntry <= VEC_BASE + 8'h04)
        else $error("own entry out of table");
    cover property ($fell(reqTwoOut));
    cover property (!reqThreeOeN && $rose(vectorValid));
    cover property ($rose(vectorValid) && reqTwoOeN);
    cover property (pslverr);
endmodule

bind eip_pin_if eip_chk u_chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .reqTwoOut(reqTwoOut), .reqTwoOeN(reqTwoOeN),
    .reqThreeOeN(reqThreeOeN), .vectorValid(vectorValid), .vectorEntry(vectorEntry));

//--- verif/eip_periph_model.sv
/* Far-side model: requesting peripherals and an external master.
   Assumes the bench pulses its commands for one cycle. */
`timescale 1ns/1ps

module eip_periph
    import eip_pkg::*;
(
    input  wire logic              clk_sys,     // System clock
    input  wire logic [4:0]        reqSet,      // Raise requests
    input  wire logic [4:0]        reqClr,      // Drop requests
    input  wire logic              slvGo,       // Start a slave delivery
    input  wire logic              slow,        // Answer one cycle late
    input  wire logic [TYPE_W-1:0] typeVal,     // Type to hand over
    input  wire logic              reqTwoOut,   // Device level, pin two
    input  wire logic              reqTwoOeN,   // Device enable, pin two
    input  wire logic              reqThreeOut, // Device level, pin three
    input  wire logic              reqThreeOeN, // Device enable, pin three
    output logic      [4:0]        pins,        // Resolved pin levels
    output logic      [TYPE_W-1:0] adBus        // Low data lines
);
    logic [4:0]        held_r = 5'h00;
    logic [2:0]        slvCnt_r = 3'h0;
    logic              ackSeen_r = 1'b0;
    logic [TYPE_W-1:0] junk_r = 8'h5A;
    wire               ack0 = !reqTwoOeN && !reqTwoOut;
    wire               ack1 = !reqThreeOeN && !reqThreeOut;
    wire               drv = ((ack0 || ack1) && (!slow || ackSeen_r)) || slvCnt_r != 3'h0;
    ////////////////////////////////////////////////////////////////////////
    // Master raises zero first, select after the type has settled
    assign pins[0] = held_r[0] || slvCnt_r != 3'h0;
    assign pins[1] = held_r[1] || slvCnt_r >= 3'h4;
    // Shared pins follow the device when driven
    assign pins[2] = reqTwoOeN ? held_r[2] : reqTwoOut;
    assign pins[3] = reqThreeOeN ? held_r[3] : reqThreeOut;
    assign pins[4] = held_r[4];
    // Released lines toggle, so a stale byte never passes
    assign adBus = drv ? typeVal : junk_r;
    // Requests held until acknowledged or cleared
    always_ff @(posedge clk_sys) begin
        held_r <= (held_r | reqSet) & ~reqClr & ~{3'h0, ack1, ack0};
        ackSeen_r <= ack0 || ack1;
        junk_r <= ~junk_r;
        if (reqClr[0])
            slvCnt_r <= 3'h0;
        else if (slvGo)
            slvCnt_r <= 3'h1;
        else if (slvCnt_r != 3'h0 && slvCnt_r != 3'h7)
            slvCnt_r <= slvCnt_r + 3'h1;
    end
endmodule

//--- verif/tb_top.sv
/* Self-checking bench: registers, own entries, cascade and slave
   services. Assumes the checker binds itself. */
`timescale 1ns/1ps

module tb_top
    import eip_pkg::*;
();
    logic              clk_sys = 1'b0, reset = 1'b1, slvGo = 1'b0, slow = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0]       prdata, rd, t, pwdata = 32'h0;
    logic              pready, pslverr, errSeen, vectorValid, irqOut;
    logic              reqTwoOut, reqTwoOeN, reqThreeOut, reqThreeOeN;
    logic [TYPE_W-1:0] vectorEntry, adBus, typeVal = 8'h00;
    logic [4:0]        pins, reqSet = 5'h00, reqClr = 5'h00;
    integer            seed = 32'hE52BF8ED;
    int                err_count = 0, samples_checked = 0, ackCnt = 0, n;

    always #20 clk_sys = ~clk_sys;
    // Cycles with either acknowledge low
    always @(posedge clk_sys) begin
        if (!reqTwoOut || (!reqThreeOut && !reqThreeOeN))
            ackCnt <= ackCnt + 1;
    end

    eip_pin_if i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reqInZero(pins[0]), .reqInOne(pins[1]),
        .reqInTwo(pins[2]), .reqTwoOut(reqTwoOut), .reqTwoOeN(reqTwoOeN),
        .reqInThree(pins[3]), .reqThreeOut(reqThreeOut), .reqThreeOeN(reqThreeOeN),
        .reqInFour(pins[4]), .adBusIn(adBus), .vectorValid(vectorValid),
        .vectorEntry(vectorEntry), .irqOut(irqOut));
    eip_periph i_far (.clk_sys(clk_sys), .reqSet(reqSet), .reqClr(reqClr), .slvGo(slvGo),
        .slow(slow), .typeVal(typeVal), .reqTwoOut(reqTwoOut), .reqTwoOeN(reqTwoOeN),
        .reqThreeOut(reqThreeOut), .reqThreeOeN(reqThreeOeN), .pins(pins), .adBus(adBus));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    // Own table entry expected for input i
    function automatic logic [TYPE_W-1:0] own_entry(input int i);
        return VEC_BASE + 8'(i);
    endfunction
    // One APB transfer and an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic pulse(input logic [4:0] s, input logic [4:0] c, input logic g);
        reqSet <= s;
        reqClr <= c;
        slvGo <= g;
        @(posedge clk_sys);
        reqSet <= 5'h00;
        reqClr <= 5'h00;
        slvGo <= 1'b0;
    endtask
    task automatic wait_vec();
        for (n = 0; vectorValid !== 1'b1; n++) @(posedge clk_sys);
    endtask
    // Lines settle before the service ends
    task automatic end_srv(input logic [4:0] c);
        pulse(5'h00, c, 1'b0);
        repeat (4) @(posedge clk_sys);
        apb(1'b1, OFS_VECTOR, 32'h0);
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        // Reset values of all words, then an unmapped one
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_val(rd, i == 2 ? {27'h0, REQMASK_RST} : 32'h0);
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk_val({31'h0, errSeen} | rd, 32'h1);
        // All lines raised, one unmasked: only it may be served
        for (int i = 0; i < 5; i++) begin
            t = $random(seed);
            apb(1'b1, OFS_TRIG, t);
            apb(1'b0, OFS_TRIG, 32'h0);
            chk_val(rd, {27'h0, t[4:0]});
            apb(1'b1, OFS_REQMASK, ~(32'h1 << i));
            apb(1'b1, OFS_IMASK, 32'h1 << i);
            pulse(5'h1F, 5'h00, 1'b0);
            wait_vec();
            chk_bit(n >= 4, 1'b1);
            chk_val({24'h0, vectorEntry}, {24'h0, own_entry(i)});
            apb(1'b0, OFS_VECTOR, 32'h0);
            chk_val(rd, {15'h0, 1'b1, 5'h0, 3'(i), own_entry(i)});
            apb(1'b0, OFS_STATUS, 32'h0);
            chk_val(rd, 32'h1 << i);
            chk_bit(irqOut, 1'b1);
            apb(1'b1, OFS_IMASK, 32'h0);
            @(posedge clk_sys);
            chk_bit(irqOut, 1'b0);
            apb(1'b1, OFS_STATUS, 32'h1 << i);
            apb(1'b1, OFS_IMASK, 32'h1F);
            @(posedge clk_sys);
            chk_bit(irqOut, 1'b0);
            end_srv(5'h1F);
            do_reset();
        end
        // Cascade on both lines, prompt and late type answers
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b1, OFS_REQMASK, 32'h0);
        for (int k = 0; k < 4; k++) begin
            typeVal <= 8'($random(seed));
            slow <= k[1];
            apb(1'b1, OFS_TRIG, $random(seed));
            chk_val({30'h0, reqThreeOeN, reqTwoOeN}, 32'h0);
            t = ackCnt;
            pulse(5'h1 << k[0], 5'h00, 1'b0);
            wait_vec();
            chk_val({24'h0, vectorEntry}, {24'h0, typeVal});
            chk_val(ackCnt - t, ACK_CYCLES);
            end_srv(5'h03);
        end
        // Slave: select marks the type, pin three our request
        do_reset();
        apb(1'b1, OFS_CTRL, 32'hC);
        apb(1'b1, OFS_REQMASK, 32'h0);
        chk_val({30'h0, reqThreeOeN, reqThreeOut}, 32'h1);
        typeVal <= 8'($random(seed));
        pulse(5'h00, 5'h00, 1'b1);
        wait_vec();
        chk_val({24'h0, vectorEntry}, {24'h0, typeVal});
        end_srv(5'h01);
        apb(1'b1, OFS_CTRL, 32'h4);
        @(posedge clk_sys);
        chk_bit(reqThreeOut, 1'b0);
        test_done();
    end
    // Twenty thousand cycles means a hang
    initial begin
        #800000;
        err_count++;
        test_done();
    end
endmodule
